// ### core/nvmcd_map.svh
// Register offsets, field positions and reset values for the configuration word decoder
`ifndef NVMCD_MAP_SVH
`define NVMCD_MAP_SVH

// Image word indices
`define NVMCD_W_LED          6'h04
`define NVMCD_W_REV          6'h05
`define NVMCD_W_PCIE         6'h29
`define NVMCD_W_WDOG         6'h2e

// Control word fields
`define NVMCD_PCIE_PINDIS    15
`define NVMCD_PCIE_ALTAUX    13
`define NVMCD_PCIE_AUX       10
`define NVMCD_PCIE_WAKE      5
`define NVMCD_PCIE_RSV_HI    4
`define NVMCD_PCIE_RSV_LO    0
`define NVMCD_PCIE_RSV_VAL   5'h1c

// Watchdog word fields
`define NVMCD_WD_EN          15
`define NVMCD_WD_TO_HI       14
`define NVMCD_WD_TO_LO       11
`define NVMCD_WD_TO_MIN      4'h2
`define NVMCD_WD_TO_DEF      4'h2

// Revision word fields
`define NVMCD_REV_MAJ_HI     15
`define NVMCD_REV_MAJ_LO     12
`define NVMCD_REV_PT_HI      11
`define NVMCD_REV_PT_LO      8
`define NVMCD_REV_MIN_HI     7
`define NVMCD_REV_MIN_LO     0

// Reset values of the latched words
`define NVMCD_RST_LED        16'hffff
`define NVMCD_RST_REV        16'h0000
`define NVMCD_RST_PCIE       16'h001c
`define NVMCD_RST_WDOG       16'h1000

// Bus register byte addresses
`define NVMCD_A_LED          8'h10
`define NVMCD_A_REV          8'h14
`define NVMCD_A_STATUS       8'h20
`define NVMCD_A_MASK         8'h24
`define NVMCD_A_CTRL         8'h28
`define NVMCD_A_STATE        8'h2c
`define NVMCD_A_PCIE         8'ha4
`define NVMCD_A_WDOG         8'hb8

// Status bits
`define NVMCD_ST_DONE        0
`define NVMCD_ST_RSV_ERR     1
`define NVMCD_ST_AUX_ERR     2
`define NVMCD_ST_WD_ERR      3
`define NVMCD_ST_AUXCHG      4
`define NVMCD_ST_W           5

`define NVMCD_RESP_OKAY      2'h0
`define NVMCD_RESP_SLVERR    2'h2

`endif

// ### core/nvmcd_pkg.sv
// Types shared by the configuration word decoder
package nvmcd_pkg;
  typedef enum logic [1:0] {
    NVMCD_LED_DEFAULT,
    NVMCD_LED_ON,
    NVMCD_LED_OFF
  } nvmcd_led_t;

  typedef enum logic [2:0] {
    NVMCD_L_IDLE,
    NVMCD_L_REQ,
    NVMCD_L_WAIT,
    NVMCD_L_NEXT,
    NVMCD_L_DONE
  } nvmcd_load_t;
endpackage : nvmcd_pkg

// ### core/nvmcd_img_if.sv
// Image read request and answer between the loader and the image port
`timescale 1ns/1ps
`default_nettype none
interface nvmcd_img_if;
  logic        req;
  logic [5:0]  addr;
  logic        ack;
  logic [15:0] data;
  modport loader (output req, output addr, input ack, input data);
  modport port   (input req, input addr, output ack, output data);
endinterface : nvmcd_img_if
`default_nettype wire

// ### core/nvmcd_img_port.sv
// Bridges image read requests onto the plain image pins with a registered answer
`timescale 1ns/1ps
`default_nettype none
module nvmcd_img_port (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  nvmcd_img_if.port        img,
  output logic             pin_rd,
  output logic [5:0]       pin_addr,
  input  wire logic        pin_valid,
  input  wire logic [15:0] pin_data
);
  logic busy;
  logic ack_q;
  logic [15:0] data_q;

  assign img.ack  = ack_q;
  assign img.data = data_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy     <= 1'b0;
      pin_rd   <= 1'b0;
      pin_addr <= 6'h00;
      ack_q    <= 1'b0;
      data_q   <= 16'h0000;
    end else begin
      ack_q <= 1'b0;
      if (!busy && img.req && !ack_q) begin
        busy     <= 1'b1;
        pin_rd   <= 1'b1;
        pin_addr <= img.addr;
      end else if (busy && pin_valid) begin
        busy   <= 1'b0;
        pin_rd <= 1'b0;
        ack_q  <= 1'b1;
        data_q <= pin_data;
      end
    end
  end
endmodule : nvmcd_img_port
`default_nettype wire

// ### core/nvmcd_led_dec.sv
// Decodes one LED blink nibble into the setting for each blink state
`timescale 1ns/1ps
`default_nettype none
module nvmcd_led_dec (
  input  wire logic [3:0]          code,
  output nvmcd_pkg::nvmcd_led_t    first_blink_state,
  output nvmcd_pkg::nvmcd_led_t    second_blink_state
);
  always_comb begin
    first_blink_state  = nvmcd_pkg::NVMCD_LED_DEFAULT;
    second_blink_state = nvmcd_pkg::NVMCD_LED_DEFAULT;
    case (code)
      4'h2: second_blink_state = nvmcd_pkg::NVMCD_LED_ON;
      4'h3: second_blink_state = nvmcd_pkg::NVMCD_LED_OFF;
      4'h4: first_blink_state  = nvmcd_pkg::NVMCD_LED_ON;
      4'h5: begin
        first_blink_state  = nvmcd_pkg::NVMCD_LED_ON;
        second_blink_state = nvmcd_pkg::NVMCD_LED_ON;
      end
      4'h6: begin
        first_blink_state  = nvmcd_pkg::NVMCD_LED_ON;
        second_blink_state = nvmcd_pkg::NVMCD_LED_OFF;
      end
      4'h7: first_blink_state  = nvmcd_pkg::NVMCD_LED_OFF;
      4'h8: begin
        first_blink_state  = nvmcd_pkg::NVMCD_LED_OFF;
        second_blink_state = nvmcd_pkg::NVMCD_LED_ON;
      end
      default: begin
        first_blink_state  = nvmcd_pkg::NVMCD_LED_DEFAULT;
        second_blink_state = nvmcd_pkg::NVMCD_LED_DEFAULT;
      end
    endcase
  end
endmodule : nvmcd_led_dec
`default_nettype wire

// ### core/nvmcd_top.sv
// Configuration word loader and decoder with AXI4-Lite register access
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "nvmcd_map.svh"
module nvmcd_top #(
  parameter int TO_WIDTH = 8
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             image_rd,
  output logic [5:0]       image_addr,
  input  wire logic        image_valid,
  input  wire logic [15:0] image_data,
  input  wire logic        pcie_reset_n,
  input  wire logic        function_disable_pin,
  input  wire logic        third_software_pad,
  input  wire logic        device_off_pad,
  input  wire logic        wake_event,
  input  wire logic        in_d3cold,
  input  wire logic        link_in_l2,
  output logic             pcie_function_disabled,
  output logic             aux_power_present,
  output logic             wake_n,
  output logic             watchdog_irq_enable,
  output logic [TO_WIDTH-1:0] runtime_watchdog_timeout_field,
  output logic [2:0]       led_first_on,
  output logic [2:0]       led_first_off,
  output logic [2:0]       led_second_on,
  output logic [2:0]       led_second_off,
  output logic             config_ready,
  output logic             irq
);
  initial begin
    if (TO_WIDTH < 4) $error("TO_WIDTH must be at least 4");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Image loader
  nvmcd_img_if img ();
  nvmcd_img_port u_port (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .img       (img),
    .pin_rd    (image_rd),
    .pin_addr  (image_addr),
    .pin_valid (image_valid),
    .pin_data  (image_data)
  );

  nvmcd_pkg::nvmcd_load_t state;
  logic [1:0]  idx;
  logic [15:0] led_word;
  logic [15:0] rev_word;
  logic [15:0] pcie_word;
  logic [15:0] wdog_word;
  logic        reload_req;
  logic        done_evt;
  logic [5:0]  word_addr;

  assign word_addr = (idx == 2'd0) ? `NVMCD_W_LED :
                     (idx == 2'd1) ? `NVMCD_W_REV :
                     (idx == 2'd2) ? `NVMCD_W_PCIE : `NVMCD_W_WDOG;
  assign img.req  = (state == nvmcd_pkg::NVMCD_L_REQ);
  assign img.addr = word_addr;
  assign done_evt = (state == nvmcd_pkg::NVMCD_L_NEXT) && (idx == 2'd3);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state     <= nvmcd_pkg::NVMCD_L_REQ;
      idx       <= 2'd0;
      led_word  <= `NVMCD_RST_LED;
      rev_word  <= `NVMCD_RST_REV;
      pcie_word <= `NVMCD_RST_PCIE;
      wdog_word <= `NVMCD_RST_WDOG;
    end else begin
      case (state)
        nvmcd_pkg::NVMCD_L_REQ: state <= nvmcd_pkg::NVMCD_L_WAIT;
        nvmcd_pkg::NVMCD_L_WAIT: begin
          if (img.ack) begin
            case (idx)
              2'd0:    led_word  <= img.data;
              2'd1:    rev_word  <= img.data;
              2'd2:    pcie_word <= img.data;
              default: wdog_word <= img.data;
            endcase
            state <= nvmcd_pkg::NVMCD_L_NEXT;
          end
        end
        nvmcd_pkg::NVMCD_L_NEXT: begin
          if (idx == 2'd3) begin
            state <= nvmcd_pkg::NVMCD_L_DONE;
          end else begin
            idx   <= idx + 2'd1;
            state <= nvmcd_pkg::NVMCD_L_REQ;
          end
        end
        nvmcd_pkg::NVMCD_L_DONE: begin
          if (reload_req) begin
            idx   <= 2'd0;
            state <= nvmcd_pkg::NVMCD_L_REQ;
          end
        end
        default: state <= nvmcd_pkg::NVMCD_L_IDLE == state ? nvmcd_pkg::NVMCD_L_REQ
                                                             : nvmcd_pkg::NVMCD_L_DONE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Field decode
  logic loaded;
  logic pin_dis_en;
  logic alt_aux_sel;
  logic aux_sel;
  logic wake_pin_en;
  logic rsv_bad;
  logic aux_both;
  logic wd_low;
  logic [3:0] wd_timeout;
  logic [7:0] map_major;
  logic [7:0] map_minor;

  assign loaded      = (state == nvmcd_pkg::NVMCD_L_DONE);
  assign pin_dis_en  = pcie_word[`NVMCD_PCIE_PINDIS];
  assign alt_aux_sel = pcie_word[`NVMCD_PCIE_ALTAUX];
  assign aux_sel     = pcie_word[`NVMCD_PCIE_AUX];
  assign wake_pin_en = pcie_word[`NVMCD_PCIE_WAKE];
  assign rsv_bad     = pcie_word[`NVMCD_PCIE_RSV_HI:`NVMCD_PCIE_RSV_LO] != `NVMCD_PCIE_RSV_VAL;
  assign aux_both    = alt_aux_sel && aux_sel;
  assign wd_timeout  = wdog_word[`NVMCD_WD_TO_HI:`NVMCD_WD_TO_LO];
  assign wd_low      = wdog_word[`NVMCD_WD_EN] && (wd_timeout < `NVMCD_WD_TO_MIN);
  assign map_major   = {4'h0, rev_word[`NVMCD_REV_MAJ_HI:`NVMCD_REV_MAJ_LO]};
  assign map_minor   = rev_word[`NVMCD_REV_MIN_HI:`NVMCD_REV_MIN_LO];

  // Disable pin is caught after power-up release and while PCIe reset is held
  logic pin_sampled;
  logic first_sample;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_sampled  <= 1'b1;
      first_sample <= 1'b1;
    end else if (first_sample || !pcie_reset_n) begin
      pin_sampled  <= function_disable_pin;
      first_sample <= 1'b0;
    end
  end

  logic next_aux;
  logic next_wake_n;
  assign next_aux = (alt_aux_sel && third_software_pad) ||
                    (aux_sel && device_off_pad);
  assign next_wake_n = !(loaded && wake_event && !link_in_l2 &&
                         (in_d3cold || wake_pin_en));

  logic [2:0] f_on;
  logic [2:0] f_off;
  logic [2:0] s_on;
  logic [2:0] s_off;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_led
      nvmcd_pkg::nvmcd_led_t st1;
      nvmcd_pkg::nvmcd_led_t st2;
      nvmcd_led_dec u_dec (
        .code               (led_word[g*4 +: 4]),
        .first_blink_state  (st1),
        .second_blink_state (st2)
      );
      assign f_on[g]  = st1 == nvmcd_pkg::NVMCD_LED_ON;
      assign f_off[g] = st1 == nvmcd_pkg::NVMCD_LED_OFF;
      assign s_on[g]  = st2 == nvmcd_pkg::NVMCD_LED_ON;
      assign s_off[g] = st2 == nvmcd_pkg::NVMCD_LED_OFF;
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Registered device outputs
  logic aux_prev;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pcie_function_disabled         <= 1'b1;
      aux_power_present              <= 1'b0;
      aux_prev                       <= 1'b0;
      wake_n                         <= 1'b1;
      watchdog_irq_enable            <= 1'b0;
      runtime_watchdog_timeout_field <= TO_WIDTH'(`NVMCD_WD_TO_DEF);
      led_first_on                   <= 3'h0;
      led_first_off                  <= 3'h0;
      led_second_on                  <= 3'h0;
      led_second_off                 <= 3'h0;
      config_ready                   <= 1'b0;
    end else begin
      pcie_function_disabled <= !loaded || (pin_dis_en && !pin_sampled);
      aux_power_present      <= loaded && next_aux;
      aux_prev               <= aux_power_present;
      wake_n                 <= next_wake_n;
      watchdog_irq_enable    <= wdog_word[`NVMCD_WD_EN];
      runtime_watchdog_timeout_field <= TO_WIDTH'(wd_timeout);
      led_first_on           <= f_on;
      led_first_off          <= f_off;
      led_second_on          <= s_on;
      led_second_off         <= s_off;
      config_ready           <= loaded;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask
  logic [`NVMCD_ST_W-1:0] status;
  logic [`NVMCD_ST_W-1:0] mask;
  logic [`NVMCD_ST_W-1:0] evt;
  logic [`NVMCD_ST_W-1:0] clr;
  logic                   wr_go;
  logic                   done_q;

  assign evt[`NVMCD_ST_DONE]    = done_evt;
  assign evt[`NVMCD_ST_RSV_ERR] = done_q && rsv_bad;
  assign evt[`NVMCD_ST_AUX_ERR] = done_q && aux_both;
  assign evt[`NVMCD_ST_WD_ERR]  = done_q && wd_low;
  assign evt[`NVMCD_ST_AUXCHG]  = aux_power_present != aux_prev;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= '0;
      done_q <= 1'b0;
      irq    <= 1'b0;
    end else begin
      done_q <= done_evt;
      status <= (status & ~clr) | evt;
      irq    <= |(((status & ~clr) | evt) & mask);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic [7:0]  aw_q;
  logic        aw_have;
  logic [31:0] w_q;
  logic [3:0]  ws_q;
  logic        w_have;
  logic        ctrl_reload;
  logic        wr_hit;
  logic [31:0] rd_val;
  logic        rd_hit;

  assign wr_go  = aw_have && w_have && !s_axi_bvalid;
  assign wr_hit = (aw_q == `NVMCD_A_STATUS) || (aw_q == `NVMCD_A_MASK) ||
                  (aw_q == `NVMCD_A_CTRL);
  assign clr    = (wr_go && aw_q == `NVMCD_A_STATUS && ws_q[0]) ? w_q[`NVMCD_ST_W-1:0] : '0;
  assign ctrl_reload = wr_go && (aw_q == `NVMCD_A_CTRL) && ws_q[0] && w_q[0];
  assign reload_req  = ctrl_reload;

  assign rd_hit = 1'b1;
  always_comb begin
    rd_val = 32'h0000_0000;
    case (s_axi_araddr)
      `NVMCD_A_LED:    rd_val = {16'h0000, led_word};
      `NVMCD_A_REV:    rd_val = {16'h0000, map_major[3:0], 4'h0, map_minor};
      `NVMCD_A_PCIE:   rd_val = {16'h0000, pcie_word};
      `NVMCD_A_WDOG:   rd_val = {16'h0000, wdog_word};
      `NVMCD_A_STATUS: rd_val = {27'h0, status};
      `NVMCD_A_MASK:   rd_val = {27'h0, mask};
      `NVMCD_A_CTRL:   rd_val = 32'h0000_0000;
      `NVMCD_A_STATE:  rd_val = {28'h0, pin_sampled, aux_power_present, config_ready, loaded};
      default:         rd_val = 32'hffff_ffff;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      w_have  <= 1'b0;
      aw_q    <= 8'h00;
      w_q     <= 32'h0000_0000;
      ws_q    <= 4'h0;
      mask    <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `NVMCD_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `NVMCD_RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have <= 1'b1;
        aw_q    <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have <= 1'b1;
        w_q    <= s_axi_wdata;
        ws_q   <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have      <= 1'b0;
        w_have       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `NVMCD_RESP_OKAY : `NVMCD_RESP_SLVERR;
        if (aw_q == `NVMCD_A_MASK && ws_q[0]) begin
          mask <= w_q[`NVMCD_ST_W-1:0];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= (rd_val == 32'hffff_ffff && rd_hit) ? 32'h0000_0000 : rd_val;
        s_axi_rresp  <= (rd_val == 32'hffff_ffff) ? `NVMCD_RESP_SLVERR : `NVMCD_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_have && !(s_axi_wvalid && s_axi_wready);
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
    end
  end
endmodule : nvmcd_top
`default_nettype wire

// ### tb/nvmcd_properties.sv
// Port assertions for the configuration word decoder
`timescale 1ns/1ps
`default_nettype none
`include "nvmcd_map.svh"
module nvmcd_checker #(
  parameter int TO_WIDTH = 8
) (
  input wire logic                aclk,
  input wire logic                aresetn,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic                image_rd,
  input wire logic [5:0]          image_addr,
  input wire logic                image_valid,
  input wire logic [15:0]         image_data,
  input wire logic                third_software_pad,
  input wire logic                device_off_pad,
  input wire logic                wake_event,
  input wire logic                in_d3cold,
  input wire logic                link_in_l2,
  input wire logic                pcie_function_disabled,
  input wire logic                aux_power_present,
  input wire logic                wake_n,
  input wire logic                watchdog_irq_enable,
  input wire logic [TO_WIDTH-1:0] runtime_watchdog_timeout_field,
  input wire logic                config_ready
);
  logic [15:0] pc_q;
  logic [15:0] wd_q;
  wire take_pc = image_rd && image_valid && image_addr == `NVMCD_W_PCIE;
  wire take_wd = image_rd && image_valid && image_addr == `NVMCD_W_WDOG;
  wire aux_ok  = !(pc_q[13] && pc_q[10]);
  wire aux_exp = pc_q[13] && third_software_pad || pc_q[10] && device_off_pad;
  wire wake_go = wake_event && !link_in_l2 && (in_d3cold || pc_q[5]);
  // Shadow copies of the control and watchdog words as they cross the image pins
  always_ff @(posedge aclk) begin
    if (!aresetn) {pc_q, wd_q} <= {`NVMCD_RST_PCIE, `NVMCD_RST_WDOG};
    else if (take_pc) pc_q <= image_data;
    else if (take_wd) wd_q <= image_data;
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_gap;
    !image_rd [*2];
  endsequence
  property p_load_start;
    $rose(aresetn) |-> ##[1:4] (image_rd && image_addr == `NVMCD_W_LED);
  endproperty
  a_load_start: assert property (p_load_start) else $error("load start late");
  property p_dis_early; !config_ready |-> pcie_function_disabled; endproperty
  a_dis_early: assert property (p_dis_early) else $error("enabled before load");
  property p_img_hold;
    image_rd && !image_valid |=> image_rd && $stable(image_addr);
  endproperty
  a_img_hold: assert property (p_img_hold) else $error("read request dropped");
  property p_img_gap; image_rd && image_valid |=> s_gap; endproperty
  a_img_gap: assert property (p_img_gap) else $error("read not released");
  property p_wd_en;
    $rose(config_ready) |-> watchdog_irq_enable == wd_q[15];
  endproperty
  a_wd_en: assert property (p_wd_en) else $error("watchdog enable wrong");
  property p_wd_to;
    $rose(config_ready) |-> runtime_watchdog_timeout_field == TO_WIDTH'(wd_q[14:11]);
  endproperty
  a_wd_to: assert property (p_wd_to) else $error("timeout field wrong");
  property p_aux;
    config_ready && aux_ok |=> aux_power_present == $past(aux_exp);
  endproperty
  a_aux: assert property (p_aux) else $error("aux power wrong");
  property p_wake_on;
    config_ready && wake_go |=> !wake_n;
  endproperty
  a_wake_on: assert property (p_wake_on) else $error("wake missing");
  property p_wake_off;
    config_ready && !wake_event |=> wake_n;
  endproperty
  a_wake_off: assert property (p_wake_off) else $error("wake without event");
  property p_bdone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_bdone: assert property (p_bdone) else $error("write answer repeated");
  property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
endmodule : nvmcd_checker
bind nvmcd_top nvmcd_checker #(.TO_WIDTH(TO_WIDTH)) u_chk (.*);
`default_nettype wire

// ### tb/nvmcd_image_model.sv
// Behavioural image store answering word reads after a settable delay
`timescale 1ns/1ps
`default_nettype none
module nvmcd_image_model (
  input  wire logic        aclk,
  input  wire logic        image_rd,
  input  wire logic [5:0]  image_addr,
  input  wire logic [3:0]  answer_delay,
  output logic             image_valid,
  output logic [15:0]      image_data
);
  logic [15:0] mem [0:63];
  logic [3:0]  wait_cnt = 4'h0;
  logic        answered = 1'b0;
  wire         give = image_rd && !answered && wait_cnt == answer_delay;
  initial {image_valid, image_data} = 17'h0;
  // Idle data lines keep changing so a stale word never looks good
  always @(posedge aclk) begin
    image_valid <= give;
    image_data <= give ? mem[image_addr] : ~image_data;
    answered <= image_rd && (answered || give);
    wait_cnt <= (image_rd && !answered && !give) ? wait_cnt + 4'h1 : 4'h0;
  end
endmodule : nvmcd_image_model
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the configuration word decoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        pcie_reset_n = 1'b1;
  logic        function_disable_pin = 1'b1;
  logic        third_software_pad = 1'b0;
  logic        device_off_pad = 1'b0;
  logic        wake_event = 1'b0;
  logic        in_d3cold = 1'b0;
  logic        link_in_l2 = 1'b0;
  logic [3:0]  img_delay = 4'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        image_rd, image_valid, pcie_function_disabled, aux_power_present, wake_n;
  logic        watchdog_irq_enable, config_ready, irq;
  logic [5:0]  image_addr;
  logic [15:0] image_data;
  logic [7:0]  runtime_watchdog_timeout_field;
  logic [2:0]  led_first_on, led_first_off, led_second_on, led_second_off;
  int          fail_count = 0;
  int          tests_run = 0;
  nvmcd_top #(.TO_WIDTH(8)) u_dut (.*);
  nvmcd_image_model u_img (.*, .answer_delay(img_delay));
  always #20 aclk = ~aclk;
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic stop_test();
    if (fail_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test
  task automatic bound(input int n);
    if (n >= 200) begin
      fail_count++;
      stop_test();
    end
  endtask : bound
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    for (int k = 0; k < 17; k++) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    return s;
  endfunction : lfsr
  // One bus transfer, write or read, with the answer compared
  task automatic xfer(input bit w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready) break;
    end
    {s_axi_bready, s_axi_rready} <= 2'b00;
    bound(n);
    chk("resp", er, w ? s_axi_bresp : s_axi_rresp);
    if (!w) chk("rdata", ed, s_axi_rdata);
  endtask : xfer
  // Blink settings per code: 0 default, 1 on, 2 off
  function automatic logic [11:0] led_exp(input logic [15:0] w);
    int f[16] = '{0, 0, 0, 0, 1, 1, 1, 2, 2, 0, 0, 0, 0, 0, 0, 0};
    int s[16] = '{0, 0, 1, 2, 0, 1, 2, 0, 1, 0, 0, 0, 0, 0, 0, 0};
    int c;
    logic [11:0] r;
    r = 12'h000;
    for (int g = 0; g < 3; g++) begin
      c = int'((w >> (4 * g)) & 16'h000f);
      r[9 + g] = f[c] == 1;
      r[6 + g] = f[c] == 2;
      r[3 + g] = s[c] == 1;
      r[g] = s[c] == 2;
    end
    return r;
  endfunction : led_exp
  task automatic load(input logic [15:0] pc, wd, led, rev, input int dl, input logic pin);
    int n;
    u_img.mem[6'h04] = led;
    u_img.mem[6'h05] = rev;
    u_img.mem[6'h29] = pc;
    u_img.mem[6'h2e] = wd;
    @(posedge aclk);
    aresetn <= 1'b0;
    img_delay <= 4'(dl);
    function_disable_pin <= pin;
    {device_off_pad, third_software_pad} <= 2'b00;
    repeat (2) @(posedge aclk);
    chk("dis_rst", 1, pcie_function_disabled);
    aresetn <= 1'b1;
    for (n = 0; n < 200 && config_ready !== 1'b1; n++) @(posedge aclk);
    bound(n);
    chk("dis", pc[15] & ~pin, pcie_function_disabled);
    chk("wd_en", wd[15], watchdog_irq_enable);
    chk("wd_to", wd[14:11], runtime_watchdog_timeout_field);
    chk("led", led_exp(led), {led_first_on, led_first_off, led_second_on, led_second_off});
    xfer(0, 8'h10, 0, led, 2'h0);
    xfer(0, 8'h14, 0, rev, 2'h0);
    xfer(0, 8'ha4, 0, pc, 2'h0);
    xfer(0, 8'hb8, 0, wd, 2'h0);
    xfer(0, 8'h20, 0, {wd[15] && wd[14:11] < 4'h2, pc[13] & pc[10], pc[4:0] != 5'h1c, 1'b1}, 0);
    for (int k = 0; k < 4; k++) begin
      {device_off_pad, third_software_pad} <= 2'(k);
      repeat (2) @(posedge aclk);
      if (!(pc[13] && pc[10])) chk("aux", pc[13] & k[0] | pc[10] & k[1], aux_power_present);
    end
    {device_off_pad, third_software_pad} <= 2'b00;
    for (int k = 0; k < 8; k++) begin
      {wake_event, in_d3cold, link_in_l2} <= 3'(k);
      repeat (2) @(posedge aclk);
      chk("wake", !(k[2] && !k[0] && (k[1] || pc[5])), wake_n);
    end
    {wake_event, in_d3cold, link_in_l2} <= 3'b000;
  endtask : load
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    logic [15:0] pc, wd;
    r = 32'heeab;
    for (int i = 0; i < 6; i++) begin
      r = lfsr(r);
      pc = r[15:0];
      r = lfsr(r);
      wd = r[15:0];
      if (i < 4) begin
        pc[4:0] = 5'h1c;
        pc[10] = pc[10] & ~pc[13];
        if (wd[14:11] < 4'h2) wd[14:11] = 4'h2;
      end
      if (i == 5) pc = {pc[15:5], 5'h03} | 16'h2400;
      if (i == 5) wd[15:11] = 5'h11;
      load(pc, wd, {4'hf, 4'(3 * i + 2), 4'(3 * i + 1), 4'(3 * i)}, r[31:16] & 16'hf0ff,
           i * 3, r[20]);
    end
    load(16'h801c, 16'h1000, 16'hffff, 16'h0000, 0, 1'b1);
    function_disable_pin <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("dis_hold", 0, pcie_function_disabled);
    pcie_reset_n <= 1'b0;
    repeat (2) @(posedge aclk);
    pcie_reset_n <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("dis_resample", 1, pcie_function_disabled);
    chk("irq_masked", 0, irq);
    xfer(1, 8'h24, 32'h1, 0, 2'h0);
    repeat (2) @(posedge aclk);
    chk("irq_set", 1, irq);
    xfer(1, 8'h20, 32'h1, 0, 2'h0);
    xfer(0, 8'h20, 0, 0, 2'h0);
    chk("irq_clr", 0, irq);
    xfer(0, 8'h3c, 0, 0, 2'h2);
    xfer(1, 8'h10, 32'h5, 0, 2'h2);
    xfer(1, 8'h3c, 32'h1, 0, 2'h2);
    xfer(0, 8'h10, 0, 32'hffff, 2'h0);
    stop_test();
  end
endmodule : testbench
`default_nettype wire
